// file: ppdu_defs.svh
// register offsets, field positions, reset values and counts for the datapath unit
`ifndef PPDU_DEFS_SVH
`define PPDU_DEFS_SVH
`define PPDU_OFS_BLOCK_CTRL 8'h00
`define PPDU_OFS_DP_CTRL 8'h04
`define PPDU_OFS_DP_SEL 8'h08
`define PPDU_OFS_DP_DATA 8'h0C
`define PPDU_OFS_STATUS 8'h10
`define PPDU_WMASK_BLOCK_CTRL 32'h820000FF
`define PPDU_WMASK_DP_CTRL 32'h00000F07
`define PPDU_WMASK_DP_SEL 32'h330F0F0F
`define PPDU_WMASK_DP_DATA 32'h000000FF
`define PPDU_RST_REG 32'h00000000
`define PPDU_BIT_ENABLE 31
`define PPDU_BIT_PIPELINE 25
`define PPDU_BYPASS_ALL 8'hFF
`define PPDU_RST_CYCLES 2'h3
`define PPDU_MAJ_A 8'h03
`define PPDU_MAJ_B 8'h05
`define PPDU_MAJ_C 8'h06
`define PPDU_MAJ_D 8'h07
`define PPDU_SEL_LUT_BASE 4'h3
`define PPDU_SEL_LUT_LAST 4'hA
`define PPDU_RESP_OKAY 2'h0
`define PPDU_RESP_SLVERR 2'h2
`endif

// file: ppdu_pkg.sv
// types for the datapath unit
`default_nettype none
package ppdu_pkg;
   typedef enum logic [3:0] {
      PPDU_OP_UP = 4'h1, PPDU_OP_DOWN = 4'h2, PPDU_OP_UP_WRAP = 4'h3,
      PPDU_OP_DOWN_WRAP = 4'h4, PPDU_OP_UPDOWN = 4'h5, PPDU_OP_UPDOWN_WRAP = 4'h6,
      PPDU_OP_ROTATE = 4'h7, PPDU_OP_SHIFT = 4'h8, PPDU_OP_ANDOR = 4'h9,
      PPDU_OP_MAJ_SHIFT = 4'hA, PPDU_OP_CMP_SHIFT = 4'hB
   } ppdu_op_t;
   typedef struct packed {
      logic [1:0] pad3;
      logic [1:0] ref_sel;
      logic [1:0] pad2;
      logic [1:0] init_sel;
      logic [3:0] pad1;
      logic [3:0] step2_sel;
      logic [3:0] pad0;
      logic [3:0] step1_sel;
      logic [3:0] pad00;
      logic [3:0] reload_sel;
   } ppdu_sel_t;
   typedef struct packed {
      logic [19:0] pad1;
      logic [3:0] opcode;
      logic [4:0] pad0;
      logic [2:0] width;
   } ppdu_dpctl_t;
endpackage : ppdu_pkg
`default_nettype wire

// file: ppdu_top.sv
// pin path datapath unit with block controls and axi4-lite register slave
// Functional notes
// - operand mask has low width+1 bits set; applied to state, loads, results, compares except the majority decode, which uses raw state
// - reload trigger loads masked initial value, beats other triggers; idle state holds
// - count-up steps by one until equal to reference, then holds; output at equality
// - count-up-wrap reloads initial value when stepping at reference
// - count-down steps down until masked state zero, then holds; output at zero
// - count-down-wrap reloads initial value when stepping at zero
// - up-down: first step increments to reference, second decrements to zero
// - up-down-wrap reloads initial value when stepping at a reached limit
// - rotate: output is bit 0; step rotates right within configured width
// - shift: output is bit 0; step shifts right, second trigger enters top
// - majority-shift shifts; output high when state is 3, 5, 6 or 7
// - compare-shift shifts; output high when masked state equals masked reference
// - and-or output is OR-reduction of state ANDed with masked reference; only reload changes state
// - per-pin passthrough bits 7:0 route pin straight between pad and matrix
// - pipeline enable bit 25 registers lookup and datapath outputs
// - block enable bit 31 low bypasses all pins and holds block in reset
// - block reset stays active three cycles after enable is set
// - datapath width is width field plus one
// - opcode values 1 to 11 select the eleven operations
// - trigger selectors: 0 low, 1 high, 2 own output, 3-10 lookup outputs
// - initial-value selector: 0 zero, 1 chip side, 2 pad side, 3 data register
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ppdu_defs.svh"
module ppdu_top #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pins and routing matrix
   input wire logic [7:0] pad_in,
   input wire logic [7:0] chip_in,
   input wire logic [7:0] lut_out_in,
   output logic [7:0] pad_out,
   output logic [7:0] chip_out,
   output logic datapath_trigger_out
);
   // register file
   logic [31:0] block_control_reg, dp_ctrl_reg, dp_sel_reg, dp_data_reg;
   logic aw_full_reg, w_full_reg;
   logic [ADDR_W-1:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic [7:0] state_reg, state_next;
   logic trig_reg, trig_comb;
   logic [7:0] lut_reg;
   logic [1:0] rst_cnt_reg;

   wire logic [31:0] strb_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                                  {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   wire logic do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
   wire logic [7:0] wa8 = 8'(waddr_reg) & 8'hFC;
   wire logic [7:0] ra8 = 8'(s_axi_araddr) & 8'hFC;
   wire logic wr_bc = do_write && wa8 == `PPDU_OFS_BLOCK_CTRL;
   wire logic wr_dc = do_write && wa8 == `PPDU_OFS_DP_CTRL;
   wire logic wr_ds = do_write && wa8 == `PPDU_OFS_DP_SEL;
   wire logic wr_dd = do_write && wa8 == `PPDU_OFS_DP_DATA;
   wire logic wr_hit = wr_bc || wr_dc || wr_ds || wr_dd;
   wire logic ar_take = s_axi_arvalid && s_axi_arready;

   // controls
   wire logic enable = block_control_reg[`PPDU_BIT_ENABLE];
   wire logic pipe_en = block_control_reg[`PPDU_BIT_PIPELINE];
   wire logic [7:0] bypass = enable ? block_control_reg[7:0] : `PPDU_BYPASS_ALL;
   wire logic blk_rst = !enable || rst_cnt_reg != `PPDU_RST_CYCLES;
   wire ppdu_pkg::ppdu_dpctl_t dpc = ppdu_pkg::ppdu_dpctl_t'(dp_ctrl_reg);
   wire ppdu_pkg::ppdu_sel_t dps = ppdu_pkg::ppdu_sel_t'(dp_sel_reg);
   wire logic [2:0] width = dpc.width;
   wire logic [7:0] mask = 8'hFF >> (3'h7 - width);
   wire logic [7:0] top_bit = 8'h01 << width;

   // pipeline stage on lookup and datapath outputs
   wire logic trig_eff = pipe_en ? trig_reg : trig_comb;
   wire logic [7:0] lut_eff = pipe_en ? lut_reg : lut_out_in;

   function automatic logic pick_trig(input logic [3:0] sel, input logic fb,
                                      input logic [7:0] luts);
      logic r;
      r = 1'b0;
      if (sel == 4'h1)
         r = 1'b1;
      else if (sel == 4'h2)
         r = fb;
      else if (sel >= `PPDU_SEL_LUT_BASE && sel <= `PPDU_SEL_LUT_LAST)
         r = luts[3'(sel - `PPDU_SEL_LUT_BASE)];
      return r;
   endfunction : pick_trig

   function automatic logic [7:0] pick_data(input logic [1:0] sel, input logic [7:0] chip,
                                            input logic [7:0] pad, input logic [7:0] sw);
      return (sel == 2'h1) ? chip : (sel == 2'h2) ? pad : (sel == 2'h3) ? sw : 8'h00;
   endfunction : pick_data

   wire logic tr0 = pick_trig(dps.reload_sel, trig_eff, lut_eff);
   wire logic tr1 = pick_trig(dps.step1_sel, trig_eff, lut_eff);
   wire logic tr2 = pick_trig(dps.step2_sel, trig_eff, lut_eff);
   wire logic [7:0] init_m = pick_data(dps.init_sel, chip_in, pad_in, dp_data_reg[7:0]) & mask;
   wire logic [7:0] ref_m = pick_data(dps.ref_sel, chip_in, pad_in, dp_data_reg[7:0]) & mask;

   // shared datapath terms
   wire logic eq_ref = (state_reg & mask) == ref_m;
   wire logic eq_0 = (state_reg & mask) == 8'h00;
   wire logic [7:0] incr = 8'(state_reg + 8'h01) & mask;
   wire logic [7:0] decr = 8'(state_reg - 8'h01) & mask;
   wire logic [7:0] shr = {1'b0, state_reg[7:1]} & mask;
   wire logic [7:0] rot_v = (shr & ~top_bit) | (state_reg[0] ? top_bit : 8'h00);
   wire logic [7:0] shift_v = (shr & ~top_bit) | (tr2 ? top_bit : 8'h00);
   wire logic maj = state_reg == `PPDU_MAJ_A || state_reg == `PPDU_MAJ_B ||
                    state_reg == `PPDU_MAJ_C || state_reg == `PPDU_MAJ_D;

   always_comb begin
      state_next = state_reg;
      trig_comb = 1'b0;
      case (dpc.opcode)
         ppdu_pkg::PPDU_OP_UP: begin
            trig_comb = eq_ref;
            if (tr1)
               state_next = eq_ref ? state_reg : incr;
         end
         ppdu_pkg::PPDU_OP_UP_WRAP: begin
            trig_comb = eq_ref;
            if (tr1)
               state_next = eq_ref ? init_m : incr;
         end
         ppdu_pkg::PPDU_OP_DOWN: begin
            trig_comb = eq_0;
            if (tr1)
               state_next = eq_0 ? state_reg : decr;
         end
         ppdu_pkg::PPDU_OP_DOWN_WRAP: begin
            trig_comb = eq_0;
            if (tr1)
               state_next = eq_0 ? init_m : decr;
         end
         ppdu_pkg::PPDU_OP_UPDOWN: begin
            trig_comb = eq_ref || eq_0;
            if (tr1)
               state_next = eq_ref ? state_reg : incr;
            else if (tr2)
               state_next = eq_0 ? state_reg : decr;
         end
         ppdu_pkg::PPDU_OP_UPDOWN_WRAP: begin
            trig_comb = eq_ref || eq_0;
            if (tr1)
               state_next = eq_ref ? init_m : incr;
            else if (tr2)
               state_next = eq_0 ? init_m : decr;
         end
         ppdu_pkg::PPDU_OP_ROTATE: begin
            trig_comb = state_reg[0];
            if (tr1)
               state_next = rot_v;
         end
         ppdu_pkg::PPDU_OP_SHIFT: begin
            trig_comb = state_reg[0];
            if (tr1)
               state_next = shift_v;
         end
         ppdu_pkg::PPDU_OP_MAJ_SHIFT: begin
            trig_comb = maj;
            if (tr1)
               state_next = shift_v;
         end
         ppdu_pkg::PPDU_OP_CMP_SHIFT: begin
            trig_comb = eq_ref;
            if (tr1)
               state_next = shift_v;
         end
         ppdu_pkg::PPDU_OP_ANDOR: begin
            trig_comb = |(state_reg & ref_m);
         end
         default: begin
            state_next = state_reg;
         end
      endcase
      if (tr0)
         state_next = init_m;
   end

   // datapath and pipeline registers, held in reset by the block control
   always_ff @(posedge aclk) begin
      if (!aresetn || blk_rst) begin
         state_reg <= 8'h00;
         trig_reg <= 1'b0;
         lut_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         trig_reg <= trig_comb;
         lut_reg <= lut_out_in;
      end
   end

   // delayed release of the block reset
   always_ff @(posedge aclk) begin
      if (!aresetn || !enable)
         rst_cnt_reg <= 2'h0;
      else if (rst_cnt_reg != `PPDU_RST_CYCLES)
         rst_cnt_reg <= rst_cnt_reg + 2'h1;
   end

   // registered pin and trigger outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pad_out <= 8'h00;
         chip_out <= 8'h00;
         datapath_trigger_out <= 1'b0;
      end else begin
         for (int i = 0; i < 8; i++) begin
            pad_out[i] <= bypass[i] ? chip_in[i] : lut_eff[i];
            chip_out[i] <= bypass[i] ? pad_in[i] : lut_eff[i];
         end
         datapath_trigger_out <= trig_eff;
      end
   end

   // write channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         waddr_reg <= '0;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PPDU_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            waddr_reg <= s_axi_awaddr;
            aw_full_reg <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
            w_full_reg <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `PPDU_RESP_OKAY : `PPDU_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // register storage with byte strobes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         block_control_reg <= `PPDU_RST_REG;
         dp_ctrl_reg <= `PPDU_RST_REG;
         dp_sel_reg <= `PPDU_RST_REG;
         dp_data_reg <= `PPDU_RST_REG;
      end else begin
         if (wr_bc)
            block_control_reg <= (block_control_reg & ~(strb_mask & `PPDU_WMASK_BLOCK_CTRL))
                                 | (wdata_reg & strb_mask & `PPDU_WMASK_BLOCK_CTRL);
         if (wr_dc)
            dp_ctrl_reg <= (dp_ctrl_reg & ~(strb_mask & `PPDU_WMASK_DP_CTRL))
                           | (wdata_reg & strb_mask & `PPDU_WMASK_DP_CTRL);
         if (wr_ds)
            dp_sel_reg <= (dp_sel_reg & ~(strb_mask & `PPDU_WMASK_DP_SEL))
                          | (wdata_reg & strb_mask & `PPDU_WMASK_DP_SEL);
         if (wr_dd)
            dp_data_reg <= (dp_data_reg & ~(strb_mask & `PPDU_WMASK_DP_DATA))
                           | (wdata_reg & strb_mask & `PPDU_WMASK_DP_DATA);
      end
   end

   // read channel
   wire logic [31:0] status_w = {22'h000000, blk_rst, trig_eff, state_reg};
   wire logic rd_hit = ra8 <= `PPDU_OFS_STATUS;
   wire logic [31:0] rd_mux = (ra8 == `PPDU_OFS_BLOCK_CTRL) ? block_control_reg :
                              (ra8 == `PPDU_OFS_DP_CTRL) ? dp_ctrl_reg :
                              (ra8 == `PPDU_OFS_DP_SEL) ? dp_sel_reg :
                              (ra8 == `PPDU_OFS_DP_DATA) ? dp_data_reg :
                              (ra8 == `PPDU_OFS_STATUS) ? status_w : 32'h00000000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `PPDU_RESP_OKAY;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_hit ? `PPDU_RESP_OKAY : `PPDU_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire logic run = !blk_rst;
   wire logic [3:0] opc = dpc.opcode;

   property p_reload;
      run && tr0 |=> state_reg == $past(init_m);
   endproperty
   a_reload: assert property (p_reload) else $error("reload did not load initial value");
   property p_up_hold;
      run && !tr0 && tr1 && eq_ref && opc == 4'h1 |=> $stable(state_reg);
   endproperty
   a_up_hold: assert property (p_up_hold) else $error("count-up moved at limit");
   property p_up_wrap;
      run && !tr0 && tr1 && eq_ref && opc == 4'h3 |=> state_reg == $past(init_m);
   endproperty
   a_up_wrap: assert property (p_up_wrap) else $error("count-up-wrap did not reload");
   property p_down_step;
      run && !tr0 && tr1 && !eq_0 && opc == 4'h2 |=> state_reg == $past(decr);
   endproperty
   a_down_step: assert property (p_down_step) else $error("count-down step wrong");
   property p_updown_prio;
      run && !tr0 && tr1 && tr2 && !eq_ref && opc == 4'h5 |=> state_reg == $past(incr);
   endproperty
   a_updown_prio: assert property (p_updown_prio) else $error("increment lost priority");
   property p_rotate;
      run && !tr0 && tr1 && opc == 4'h7 |=> state_reg[$past(width)] == $past(state_reg[0]);
   endproperty
   a_rotate: assert property (p_rotate) else $error("rotate lost bit 0");
   property p_bypass;
      !enable |=> pad_out == $past(chip_in) && chip_out == $past(pad_in);
   endproperty
   a_bypass: assert property (p_bypass) else $error("disabled block not bypassed");
   property p_release;
      $rose(enable) |-> blk_rst ##1 (blk_rst || !enable) ##1 (blk_rst || !enable)
         ##1 (!blk_rst || !enable);
   endproperty
   a_release: assert property (p_release) else $error("block reset release timing");
   property p_undef;
      run && !tr0 && opc > 4'hB |=> $stable(state_reg) && !$past(trig_comb);
   endproperty
   a_undef: assert property (p_undef) else $error("undefined opcode changed state");
   property p_pipe;
      pipe_en && $past(pipe_en) && $past(run) && run |-> trig_eff == $past(trig_comb);
   endproperty
   a_pipe: assert property (p_pipe) else $error("pipelined trigger not delayed");
   c_wrap: cover property (run && tr1 && eq_ref && opc == 4'h3);
   c_shift_in: cover property (run && tr1 && tr2 && opc == 4'h8);
   c_enable: cover property ($rose(enable) ##4 run);
endmodule : ppdu_top
`default_nettype wire

// file: ppdu_matrix_model.sv
// routing-matrix side model: drives matrix-side pin data and lookup-table outputs
`timescale 1ns/10ps
`default_nettype none
module ppdu_matrix_model (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // requests from the bench
   input wire logic [7:0] lut_req,
   input wire logic [7:0] chip_req,
   // toward the unit
   output logic [7:0] lut_out_in,
   output logic [7:0] chip_in
);
   // outputs launched right after the edge, held a full cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lut_out_in <= 8'h00;
         chip_in <= 8'h00;
      end else begin
         lut_out_in <= lut_req;
         chip_in <= chip_req;
      end
   end
endmodule : ppdu_matrix_model
`default_nettype wire

// file: tb_ppdu_top.sv
// self-checking bench for the pin path datapath unit
`timescale 1ns/10ps
`default_nettype none
`include "ppdu_defs.svh"
module tb_ppdu_top;
   logic aclk;
   logic aresetn;
   logic [7:0] awaddr, araddr, pad_in, chip_in, lut_out_in, lut_req, chip_req, pad_out, chip_out;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic trig;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   int err_count = 0;
   int total_checks = 0;
   int cyc = 0;
   // operation table: opcode, trigger bits, steps, reload first, state, trigger
   logic [3:0] t_op [14] = '{1, 1, 3, 2, 4, 5, 5, 6, 7, 8, 4'hA, 4'hB, 9, 4'hC};
   logic [7:0] t_bits [14] = '{3, 2, 2, 2, 2, 6, 4, 4, 2, 6, 2, 6, 2, 2};
   int t_n [14] = '{2, 3, 2, 7, 6, 2, 7, 6, 1, 2, 2, 1, 3, 3};
   logic t_rl [14] = '{0, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 0};
   logic [7:0] t_st [14] = '{5, 6, 5, 0, 5, 6, 0, 5, 6, 7, 1, 6, 5, 5};
   logic t_tg [14] = '{0, 1, 0, 1, 0, 1, 1, 0, 0, 1, 0, 1, 1, 0};

   ppdu_top ppdu_top_i (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pad_in(pad_in), .chip_in(chip_in), .lut_out_in(lut_out_in),
      .pad_out(pad_out), .chip_out(chip_out), .datapath_trigger_out(trig)
   );

   ppdu_matrix_model ppdu_matrix_model_i (
      .aclk(aclk), .aresetn(aresetn), .lut_req(lut_req), .chip_req(chip_req),
      .lut_out_in(lut_out_in), .chip_in(chip_in)
   );

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   task automatic give_verdict();
      if (err_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict

   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   // axi4-lite write: address and data offered together, held until taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      check("bresp", {30'h0, bresp}, {30'h0, er});
   endtask : wr

   // axi4-lite read with expected data and response
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      check("rresp", {30'h0, rresp}, {30'h0, er});
      check("rdata", rdata, e);
   endtask : rd

   // lookup-table outputs high for exactly n cycles, then settle
   task automatic pulse(input logic [7:0] b, input int n);
      @(posedge aclk);
      lut_req <= b;
      repeat (n) @(posedge aclk);
      lut_req <= 8'h00;
      repeat (4) @(posedge aclk);
   endtask : pulse

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         give_verdict();
      end
   end

   initial begin
      aresetn = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h00000000;
      wstrb = 4'hF;
      pad_in = 8'hA5;
      lut_req = 8'h00;
      chip_req = 8'h3C;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`PPDU_OFS_BLOCK_CTRL, `PPDU_RST_REG, `PPDU_RESP_OKAY);
      rd(`PPDU_OFS_STATUS, 32'h00000200, `PPDU_RESP_OKAY);
      rd(8'h14, 32'h00000000, `PPDU_RESP_SLVERR);
      wr(8'h14, 32'hFFFFFFFF, `PPDU_RESP_SLVERR);
      wr(`PPDU_OFS_DP_CTRL, 32'hFFFFFFFF, `PPDU_RESP_OKAY);
      rd(`PPDU_OFS_DP_CTRL, `PPDU_WMASK_DP_CTRL, `PPDU_RESP_OKAY);
      wr(`PPDU_OFS_BLOCK_CTRL, 32'h02000000, `PPDU_RESP_OKAY);
      repeat (3) @(posedge aclk);
      check("chip_out", {24'h0, chip_out}, 32'h000000A5);
      check("pad_out", {24'h0, pad_out}, 32'h0000003C);
      chip_req <= 8'hFE;
      wr(`PPDU_OFS_DP_SEL, 32'h13050403, `PPDU_RESP_OKAY);
      wr(`PPDU_OFS_DP_DATA, 32'h0000000D, `PPDU_RESP_OKAY);
      wr(`PPDU_OFS_BLOCK_CTRL, 32'h82000000, `PPDU_RESP_OKAY);
      repeat (5) @(posedge aclk);
      rd(`PPDU_OFS_STATUS, 32'h00000000, `PPDU_RESP_OKAY);
      for (int i = 0; i < 14; i++) begin
         wr(`PPDU_OFS_DP_CTRL, {20'h0, t_op[i], 8'h02}, `PPDU_RESP_OKAY);
         if (t_rl[i]) pulse(8'h01, 1);
         pulse(t_bits[i], t_n[i]);
         rd(`PPDU_OFS_STATUS, {23'h0, t_tg[i], t_st[i]}, 2'h0);
         check("trigger_out", {31'h0, trig}, {31'h0, t_tg[i]});
      end
      // constant-high reload of pad-side value, full width, and-or against pad side
      wr(`PPDU_OFS_DP_SEL, 32'h22000001, `PPDU_RESP_OKAY);
      wr(`PPDU_OFS_DP_CTRL, 32'h00000907, `PPDU_RESP_OKAY);
      rd(`PPDU_OFS_STATUS, 32'h000001A5, `PPDU_RESP_OKAY);
      wr(`PPDU_OFS_BLOCK_CTRL, 32'h8000000F, `PPDU_RESP_OKAY);
      repeat (3) @(posedge aclk);
      check("chip_out", {24'h0, chip_out}, 32'h00000005);
      check("pad_out", {24'h0, pad_out}, 32'h0000000E);
      check("trigger_out", {31'h0, trig}, 32'h00000001);
      // unpipelined lookup outputs reach the pins one cycle sooner
      lut_req <= 8'hF0;
      repeat (3) @(posedge aclk);
      check("pad_out", {24'h0, pad_out}, 32'h000000FE);
      check("chip_out", {24'h0, chip_out}, 32'h000000F5);
      give_verdict();
   end
endmodule : tb_ppdu_top
`default_nettype wire
